/* shared/scs_pkg.sv */
// shared constants and types of the conversion sequencer
package scs_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int CMD_MIN_NS = 100;
   localparam int CONV_MAX_NS = 35000;
   localparam int RESULT_BITS = 16;
   localparam int CNT_W = 12;
   // least time rounds up, longest time rounds down
   localparam int CMD_MIN_CYC = (CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int BIT_CYCLES = CONV_MAX_CYC / RESULT_BITS;
   localparam logic [CNT_W-1:0] CMD_MIN_CNT = CNT_W'(CMD_MIN_CYC);
   localparam logic [15:0] START_PATTERN = 16'h7FFF;
   localparam logic [3:0] MSB_INDEX = 4'hF;
   localparam int RANGE_BIPOLAR_BIT = 1;

   typedef enum logic [0:0] {
      SCS_IDLE = 1'b0,
      SCS_BUSY = 1'b1
   } scs_state_type;

   typedef struct packed {
      scs_state_type state;
      logic [15:0] data;
      logic [3:0] idx;
      logic bipolar;
      logic prev_cmd;
      logic [CNT_W-1:0] high_cnt;
   } scs_seq_type;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } scs_div_type;
endpackage : scs_pkg

/* shared/scs_if.sv */
// carrier between the sequencer and its bit clock divider
`timescale 1ns/1ps
`default_nettype none
interface scs_if;
   logic busy;
   logic tick;
   modport seq (output busy, input tick);
   modport div (input busy, output tick);
endinterface : scs_if
`default_nettype wire

/* rtl/scs_bit_clock.sv */
// bit clock divider: one enable pulse per bit trial while busy
`timescale 1ns/1ps
`default_nettype none
module scs_bit_clock
#(
   parameter int BIT_CYCLES = scs_pkg::BIT_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // sequencer side
   scs_if.div bus
);
   import scs_pkg::*;

   generate
      if (BIT_CYCLES < 2 || BIT_CYCLES >= (1 << CNT_W)) begin : g_bad_div
         $error("scs_bit_clock: BIT_CYCLES out of range");
      end
   endgenerate

   localparam logic [CNT_W-1:0] LAST = CNT_W'(BIT_CYCLES - 1);

   scs_div_type st;
   scs_div_type next_st;

   // idle holds the count at zero, so every conversion starts a fresh bit period
   always_comb begin
      next_st = st;
      if (!bus.busy) begin
         next_st.cnt = '0;
      end else if (st.cnt == LAST) begin
         next_st.cnt = '0;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.tick = bus.busy && (st.cnt == LAST);
endmodule : scs_bit_clock
`default_nettype wire

/* rtl/scs_sequencer.sv */
// successive-approximation conversion sequencer, top level
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer
#(
   parameter int BIT_CYCLES = scs_pkg::BIT_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // command and analog decision
   input wire logic i_convert,
   input wire logic i_comp_keep,
   // range strap: bit 1 high selects bipolar
   input wire logic [1:0] i_range_sel,
   // status and result
   output logic o_status,
   output logic [15:0] o_data,
   output logic o_msb_true,
   output logic o_msb_comp,
   output logic o_bipolar
);
   import scs_pkg::*;

   generate
      if (RESULT_BITS * BIT_CYCLES + 1 > CONV_MAX_CYC) begin : g_bad_seq
         $error("scs_sequencer: BIT_CYCLES too long for the conversion limit");
      end
   endgenerate

   scs_if bus ();

   scs_bit_clock #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_bit_clock (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .bus(bus)
   );

   scs_seq_type st;
   scs_seq_type next_st;
   logic cmd_fall;
   logic accept;
   logic last_tick;
   logic [3:0] idx_dn;

   // short command pulses are refused rather than trusted
   assign cmd_fall = st.prev_cmd && !i_convert;
   assign accept = (st.state == SCS_IDLE) && cmd_fall && (st.high_cnt >= CMD_MIN_CNT);
   assign last_tick = (st.state == SCS_BUSY) && bus.tick && (st.idx == 4'h0);
   assign idx_dn = st.idx - 4'h1;

   always_comb begin
      next_st = st;
      next_st.prev_cmd = i_convert;
      if (!i_convert) begin
         next_st.high_cnt = '0;
      end else if (st.high_cnt != CMD_MIN_CNT) begin
         next_st.high_cnt = st.high_cnt + 1'b1;
      end
      unique case (st.state)
         SCS_IDLE: begin
            if (accept) begin
               next_st.state = SCS_BUSY;
               next_st.data = START_PATTERN;
               next_st.idx = MSB_INDEX;
               // strap is caught per conversion, so coding never changes mid-result
               next_st.bipolar = i_range_sel[RANGE_BIPOLAR_BIT];
            end
         end
         SCS_BUSY: begin
            if (bus.tick) begin
               // trial value is low; a rejected trial returns the bit high
               if (!i_comp_keep) begin
                  next_st.data[st.idx] = 1'b1;
               end
               if (st.idx == 4'h0) begin
                  next_st.state = SCS_IDLE;
               end else begin
                  next_st.idx = idx_dn;
                  next_st.data[idx_dn] = 1'b0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.busy = (st.state == SCS_BUSY);
   assign o_status = (st.state == SCS_BUSY);
   assign o_data = st.data;
   assign o_msb_true = st.data[15];
   assign o_msb_comp = ~st.data[15];
   assign o_bipolar = st.bipolar;

   // helper: cycles since the accepted command, only read by assertions
   logic [CNT_W-1:0] conv_cnt;
   localparam int BIT_SPAN = BIT_CYCLES;
   localparam int CONV_END = RESULT_BITS * BIT_CYCLES + 1;
   localparam int CONV_LIMIT = CONV_MAX_CYC;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         conv_cnt <= '0;
      end else if (accept) begin
         conv_cnt <= 12'h001;
      end else if (o_status) begin
         conv_cnt <= conv_cnt + 12'h001;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);

   a_start_on_fall: assert property (
      (!o_status && $past(i_convert) && !i_convert && st.high_cnt >= CMD_MIN_CNT)
      |=> o_status)
      else $error("valid falling command edge did not start a conversion");

   a_short_refused: assert property (
      (!o_status && $past(i_convert) && !i_convert && st.high_cnt < CMD_MIN_CNT)
      |=> !o_status)
      else $error("short command pulse started a conversion");

   a_no_retrigger: assert property (
      (o_status && !last_tick && $fell(i_convert)) |=> (conv_cnt != 12'h001))
      else $error("command edge restarted a running conversion");

   a_start_pattern: assert property (
      accept |=> (o_data == START_PATTERN && o_msb_true == 1'b0))
      else $error("start pattern wrong");

   a_status_held: assert property (
      (o_status && !last_tick) |=> o_status)
      else $error("status dropped before the last decision");

   a_trial_low: assert property (
      (o_status && bus.tick && st.idx != 4'h0) |=> (o_data[st.idx] == 1'b0))
      else $error("next trial bit not driven low");

   a_bit_period: assert property (
      (o_status && bus.tick && st.idx != 4'h0) |-> ##[BIT_SPAN:BIT_SPAN] bus.tick)
      else $error("bit trial did not last one bit period");

   a_conv_limit: assert property (
      o_status |-> (conv_cnt <= CONV_LIMIT))
      else $error("conversion exceeded its time limit");

   a_conv_length: assert property (
      $fell(o_status) |-> (conv_cnt == CONV_END))
      else $error("conversion length wrong");

   a_status_end: assert property (
      last_tick |=> !o_status)
      else $error("status not dropped after last decision");

   a_msb_pair: assert property (
      o_msb_comp != o_msb_true)
      else $error("complemented msb equals true msb");

   a_result_hold: assert property (
      (!o_status && !accept) |=> ($stable(o_data) && $stable(o_bipolar)))
      else $error("result changed between conversions");

   c_full_conv: cover property ($fell(o_status));
   c_all_kept: cover property ($fell(o_status) && o_data == 16'h0000);
   c_bipolar_conv: cover property ($fell(o_status) && o_bipolar);
   c_busy_edge: cover property (o_status && $fell(i_convert));
endmodule : scs_sequencer
`default_nettype wire

/* bench/scs_comparator_model.sv */
// ideal comparator in code space facing the sequencer's trial outputs
`timescale 1ns/1ps
`default_nettype none
module scs_comparator_model (
   // input level as a code and present trial pattern
   input wire logic [15:0] i_vin,
   input wire logic [15:0] i_data,
   // decision back to the sequencer
   output logic o_keep
);
   // a low trial bit is kept while the input lies below the code with that bit set,
   // so the settled pattern is the input in straight binary
   assign o_keep = (i_vin <= i_data);
endmodule : scs_comparator_model
`default_nettype wire

/* bench/sar_conversion_sequencer_bench.sv */
// self-checking bench of the conversion sequencer with a comparator model
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_bench;
   import scs_pkg::*;
   // short bit window keeps the run brief
   localparam int BC = 4;
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_convert = 1'b0;
   logic [1:0] i_range_sel = 2'h0;
   logic [15:0] vin = 16'h0000;
   logic keep;
   logic o_status;
   logic [15:0] o_data;
   logic o_msb_true;
   logic o_msb_comp;
   logic o_bipolar;
   int n_fail = 0;
   int checks = 0;
   logic [15:0] exp_q[$];

   always #5 i_sys_clk = ~i_sys_clk;

   scs_sequencer #(.BIT_CYCLES(BC)) i_scs_sequencer (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_convert(i_convert),
      .i_comp_keep(keep), .i_range_sel(i_range_sel), .o_status(o_status),
      .o_data(o_data), .o_msb_true(o_msb_true), .o_msb_comp(o_msb_comp),
      .o_bipolar(o_bipolar));

   scs_comparator_model i_scs_comparator_model (
      .i_vin(vin), .i_data(o_data), .o_keep(keep));

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task automatic complete_run;
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   // host pulse: high for n_high samples, then the falling edge
   task automatic pulse(input int n_high);
      @(negedge i_sys_clk);
      i_convert = 1'b1;
      repeat (n_high) @(negedge i_sys_clk);
      i_convert = 1'b0;
   endtask : pulse

   task automatic run_conv(input logic [1:0] rs, input logic [15:0] v);
      int n;
      int w;
      logic [15:0] d;
      i_range_sel = rs;
      vin = v;
      exp_q.push_back(v);
      pulse(10);
      w = 0;
      while (o_status !== 1'b1 && w < 4) begin
         @(negedge i_sys_clk);
         w++;
      end
      chk("start_data", 16'h7FFF, o_data);
      n = 0;
      // a full command pulse in mid-conversion must not restart it
      while (o_status === 1'b1 && n < 300) begin
         n++;
         if (n == 20) i_convert = 1'b1;
         if (n == 40) i_convert = 1'b0;
         @(negedge i_sys_clk);
      end
      chk("busy_cycles", 16'(16 * BC), 16'(n));
      d = exp_q.pop_front();
      chk("result", d, o_data);
      chk("msb_true", {15'h0000, d[15]}, {15'h0000, o_msb_true});
      chk("msb_comp", {15'h0000, ~d[15]}, {15'h0000, o_msb_comp});
      chk("bipolar", {15'h0000, rs[1]}, {15'h0000, o_bipolar});
      vin = 16'($urandom);
      repeat (5) @(negedge i_sys_clk);
      chk("held", d, o_data);
   endtask : run_conv

   initial begin
      repeat (5000) @(posedge i_sys_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      void'($urandom(6120));
      repeat (10) @(negedge i_sys_clk);
      chk("reset_data", 16'h0000, o_data);
      chk("reset_flags", 16'h0002, {12'h000, o_status, o_msb_true, o_msb_comp, o_bipolar});
      i_rst_b = 1'b1;
      // one sample short of the minimum pulse is refused
      pulse(9);
      repeat (3) @(negedge i_sys_clk);
      chk("short_pulse", 16'h0000, {15'h0000, o_status});
      run_conv(2'h0, 16'hFFFF);
      run_conv(2'h2, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         run_conv(2'(k), 16'($urandom));
      end
      complete_run();
   end
endmodule : sar_conversion_sequencer_bench
`default_nettype wire
